// File: dpll_ctrl_pkg.sv
`default_nettype none
package dpll_ctrl_pkg;
  // core timing
  localparam int CLK_HZ            = 25_000_000;
  localparam int RESET_HOLD_MS     = 3;
  // least time, so round up to whole cycles
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_MS * CLK_HZ + 999) / 1000;

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL    = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_TIE_DELAY  = 8'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // two-bit operating mode code
  localparam logic [1:0] MODE_NORMAL   = 2'h0;
  localparam logic [1:0] MODE_HOLDOVER = 2'h1;
  localparam logic [1:0] MODE_FREERUN  = 2'h2;
  localparam logic [1:0] MODE_AUTO     = 2'h3;

  // reference indices
  localparam int NUM_REFS = 3;
  localparam logic [1:0] REF_A = 2'h0;
  localparam logic [1:0] REF_B = 2'h1;
  localparam logic [1:0] REF_C = 2'h2;

  // reference monitor defaults, in core clock cycles; lock qualification count in reference edges
  localparam int PERIOD_W = 16;
  localparam logic [PERIOD_W-1:0] NOM_PERIOD   = 16'h0019;
  localparam logic [PERIOD_W-1:0] LIMIT_NARROW = 16'h0002;
  localparam logic [PERIOD_W-1:0] LIMIT_WIDE   = 16'h0004;
  localparam logic [PERIOD_W-1:0] JUMP_LIMIT   = 16'h0001;
  localparam int LOCK_W = 4;
  localparam logic [LOCK_W-1:0] LOCK_EDGES = 4'h8;

  // control register
  localparam logic [1:0] CTRL_REF_RESET = 2'h0;

  // interrupt bits
  localparam int IRQ_W         = 6;
  localparam int IRQ_LOCK_GAIN = 0;
  localparam int IRQ_LOCK_LOSS = 1;
  localparam int IRQ_HOLDOVER  = 2;
  localparam int IRQ_FAULT_LSB = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_FREERUN,
    ST_HOLDOVER,
    ST_NORMAL
  } loop_state_t;
endpackage
`default_nettype wire

// File: dpll_status_mode_ctrl.sv
// Notes on behaviour
// RL1: lock flag high while locked to selected reference
// RL2: holdover flag high while loop in holdover
// RL3: per-reference fault when frequency beyond chosen limit
// RL4: fault also on abrupt phase or frequency change
// RL5: rebuild select low keeps corrector delay
// RL6: rebuild select high remeasures corrector delay
// RL7: two select inputs form one mode code
// RL8: codes select normal, holdover, freerun, automatic
// RL9: low reset resets; then 3 ms outputs floated; here only frame_pulse is floated, via frame_pulse_oe
// RL10: board supplies the master timing clock
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dpll_status_mode_ctrl #(
  parameter int unsigned RESET_HOLD = dpll_ctrl_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic                              core_clk,
  input  wire logic                              rst_n,
  input  wire logic                              input_a,
  input  wire logic                              input_b,
  input  wire logic                              input_c,
  input  wire logic                              range_limit_choice,
  input  wire logic                              phase_rebuild_select,
  input  wire logic                              op_setting_bit0,
  input  wire logic                              op_setting_bit1,
  input  wire logic [dpll_ctrl_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output var  logic                              s_axi_awready,
  input  wire logic [dpll_ctrl_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output var  logic                              s_axi_wready,
  output var  logic [1:0]                        s_axi_bresp,
  output var  logic                              s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [dpll_ctrl_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output var  logic                              s_axi_arready,
  output var  logic [dpll_ctrl_pkg::DATA_W-1:0]  s_axi_rdata,
  output var  logic [1:0]                        s_axi_rresp,
  output var  logic                              s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  output var  logic                              freq_lock_flag,
  output var  logic                              holdover_flag,
  output var  logic                              input_a_fault_flag,
  output var  logic                              input_b_fault_flag,
  output var  logic                              input_c_fault_flag,
  output var  logic                              frame_pulse,
  output var  logic                              frame_pulse_oe,
  output var  logic                              irq
);
  import dpll_ctrl_pkg::*;

  // ---- reset release through two flops, then the hold timer
  logic rst_meta;
  logic sys_rst_n;
  logic in_reset_state;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta  <= 1'h0;
      sys_rst_n <= 1'h0;
    end else begin
      rst_meta  <= 1'h1;
      sys_rst_n <= rst_meta;
    end
  end

  reset_hold #(
    .HOLD (RESET_HOLD)
  ) u_hold (
    .clk   (core_clk),
    .rst_n (sys_rst_n),
    .busy  (in_reset_state)
  );

  // ---- one monitor per reference input
  wire [NUM_REFS-1:0] ref_pins = {input_c, input_b, input_a};
  logic [NUM_REFS-1:0] ref_fault;
  logic [NUM_REFS-1:0] ref_edge;

  for (genvar g = 0; g < NUM_REFS; g++) begin : g_mon
    ref_monitor u_mon (
      .clk        (core_clk),
      .rst_n      (sys_rst_n),
      .ref_in     (ref_pins[g]),
      .wide_range (range_limit_choice),
      .fault      (ref_fault[g]),
      .edge_seen  (ref_edge[g])
    );
  end

  // faults go straight out from the monitor flops
  assign input_a_fault_flag = ref_fault[REF_A];  // [RL3] [RL4]
  assign input_b_fault_flag = ref_fault[REF_B];
  assign input_c_fault_flag = ref_fault[REF_C];

  // ---- mode code and reference choice
  logic [1:0]  ctrl_ref;
  logic [1:0]  active_ref;
  loop_state_t state;
  loop_state_t next_state;

  wire [1:0] mode_code = {op_setting_bit1, op_setting_bit0};  // [RL7]
  wire       auto_any  = ~&ref_fault;
  // automatic mode prefers a, then b, then c
  wire [1:0] auto_ref  = !ref_fault[REF_A] ? REF_A :
                         !ref_fault[REF_B] ? REF_B : REF_C;
  wire [1:0] want_ref  = (mode_code == MODE_AUTO) ? auto_ref : ctrl_ref;  // [RL8]
  wire       want_good = ~ref_fault[want_ref];

  // loop state from mode code and health of the wanted reference
  always_comb begin
    next_state = state;
    if (in_reset_state) begin
      next_state = ST_RESET;  // [RL9]
    end else begin
      case (mode_code)  // [RL8]
        MODE_FREERUN:  next_state = ST_FREERUN;
        MODE_HOLDOVER: next_state = (state == ST_RESET) ? ST_FREERUN : ST_HOLDOVER;
        MODE_NORMAL,
        MODE_AUTO: begin
          if (want_good)
            next_state = ST_NORMAL;
          else if (state == ST_RESET || state == ST_FREERUN)
            next_state = ST_FREERUN;
          else
            next_state = ST_HOLDOVER;
        end
        default: next_state = ST_FREERUN;
      endcase
    end
  end

  wire entering_normal = (next_state == ST_NORMAL) && (state != ST_NORMAL);
  wire ref_change      = (next_state == ST_NORMAL) && (state == ST_NORMAL) &&
                         (want_ref != active_ref);
  wire from_hold_free  = (state == ST_HOLDOVER) || (state == ST_FREERUN);

  // ---- time-error corrector: free phase counter and held delay
  logic [PERIOD_W-1:0] phase_cnt;
  logic [PERIOD_W-1:0] tie_delay;
  logic                tie_valid;
  logic                remeasure;

  wire same_ref_return = entering_normal && from_hold_free && tie_valid &&
                         (want_ref == active_ref);
  // keeping the delay avoids a fresh measurement; high rebuild costs one edge
  wire keep_delay      = same_ref_return && !phase_rebuild_select;  // [RL5]
  wire start_measure   = (entering_normal && !keep_delay) || ref_change;  // [RL6]
  wire capture         = remeasure && (state == ST_NORMAL) && ref_edge[active_ref];
  wire phase_wrap      = (phase_cnt == NOM_PERIOD - 1'h1);

  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      phase_cnt <= '0;
      tie_delay <= '0;
      tie_valid <= 1'h0;
      remeasure <= 1'h0;
    end else begin
      phase_cnt <= phase_wrap ? '0 : phase_cnt + 1'h1;
      if (start_measure)
        remeasure <= 1'h1;  // [RL6]
      else if (capture)
        remeasure <= 1'h0;
      if (capture && !start_measure) begin
        tie_delay <= phase_cnt;  // [RL6]
        tie_valid <= 1'h1;
      end
    end
  end

  // ---- lock qualification: good edges counted on the active reference
  logic [LOCK_W-1:0] lock_cnt;
  logic [LOCK_W-1:0] next_lock_cnt;

  always_comb begin
    next_lock_cnt = lock_cnt;
    if (next_state != ST_NORMAL || entering_normal || ref_change)
      next_lock_cnt = '0;
    else if (ref_edge[active_ref] && lock_cnt != LOCK_EDGES)
      next_lock_cnt = lock_cnt + 1'h1;
  end

  wire next_lock     = (next_lock_cnt == LOCK_EDGES);  // [RL1]
  wire next_holdover = (next_state == ST_HOLDOVER);  // [RL2]

  // state, flags and timing output enable
  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      state          <= ST_RESET;
      active_ref     <= REF_A;
      lock_cnt       <= '0;
      freq_lock_flag <= 1'h0;
      holdover_flag  <= 1'h0;
      frame_pulse    <= 1'h0;
      frame_pulse_oe <= 1'h0;
    end else begin
      state          <= next_state;
      lock_cnt       <= next_lock_cnt;
      freq_lock_flag <= next_lock;  // [RL1]
      holdover_flag  <= next_holdover;  // [RL2]
      if (next_state == ST_NORMAL) active_ref <= want_ref;
      frame_pulse    <= phase_wrap & ~in_reset_state;
      frame_pulse_oe <= ~in_reset_state;  // [RL9]
    end
  end

  // ---- bus slave: write address and data taken in either order
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0]        w_strb_q;

  wire               aw_take  = s_axi_awvalid & s_axi_awready;
  wire               w_take   = s_axi_wvalid & s_axi_wready;
  wire               aw_have  = aw_held | aw_take;
  wire               w_have   = w_held | w_take;
  wire               do_write = aw_have & w_have & ~s_axi_bvalid;
  wire [ADDR_W-1:0]  wr_addr  = aw_held ? aw_addr_q : s_axi_awaddr;
  wire [DATA_W-1:0]  wr_data  = w_held ? w_data_q : s_axi_wdata;
  wire [3:0]         wr_strb  = w_held ? w_strb_q : s_axi_wstrb;
  wire               next_aw_held = aw_have & ~do_write;
  wire               next_w_held  = w_have & ~do_write;
  wire               next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);

  // write decode; all fields sit in byte lane 0
  wire wr_lane0   = do_write & wr_strb[0];
  wire wr_ctrl    = wr_lane0 & (wr_addr == ADDR_CONTROL) & (wr_data[1:0] != 2'h3);
  wire wr_clear   = wr_lane0 & (wr_addr == ADDR_IRQ_STATUS);
  wire wr_mask    = wr_lane0 & (wr_addr == ADDR_IRQ_MASK);
  wire wr_mapped  = (wr_addr == ADDR_STATUS) | (wr_addr == ADDR_CONTROL) |
                    (wr_addr == ADDR_IRQ_STATUS) | (wr_addr == ADDR_IRQ_MASK) |
                    (wr_addr == ADDR_TIE_DELAY);

  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      aw_held       <= 1'h0;
      w_held        <= 1'h0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'h0;
      s_axi_wready  <= 1'h0;
      s_axi_bvalid  <= 1'h0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      if (aw_take) aw_addr_q <= s_axi_awaddr;
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      // no new write is taken while a response waits
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready  <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (do_write) s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ---- interrupt status (write one to clear) and mask
  logic [IRQ_W-1:0]    irq_status;
  logic [IRQ_W-1:0]    irq_mask;
  logic [NUM_REFS-1:0] fault_prev;

  wire [IRQ_W-1:0] events = {ref_fault & ~fault_prev,
                             next_holdover & ~holdover_flag,
                             ~next_lock & freq_lock_flag,
                             next_lock & ~freq_lock_flag};
  // a new event wins over a clear in the same cycle
  wire [IRQ_W-1:0] next_irq_status = (irq_status &
                                      ~(wr_clear ? wr_data[IRQ_W-1:0] : IRQ_RESET)) |
                                     events;
  wire [IRQ_W-1:0] next_irq_mask   = wr_mask ? wr_data[IRQ_W-1:0] : irq_mask;

  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      irq_status <= IRQ_RESET;
      irq_mask   <= IRQ_RESET;
      fault_prev <= '0;
      ctrl_ref   <= CTRL_REF_RESET;
      irq        <= 1'h0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      fault_prev <= ref_fault;
      if (wr_ctrl) ctrl_ref <= wr_data[1:0];
      irq        <= |(next_irq_status & next_irq_mask);
    end
  end

  // ---- read side: answer one cycle after the address is taken
  wire               ar_take     = s_axi_arvalid & s_axi_arready;
  wire               next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [DATA_W-1:0]  status_word = {20'h0_0000, remeasure, tie_valid, active_ref,
                                    in_reset_state, mode_code, ref_fault,
                                    holdover_flag, freq_lock_flag};
  wire               rd_status   = (s_axi_araddr == ADDR_STATUS);
  wire               rd_ctrl     = (s_axi_araddr == ADDR_CONTROL);
  wire               rd_irq_st   = (s_axi_araddr == ADDR_IRQ_STATUS);
  wire               rd_irq_mask = (s_axi_araddr == ADDR_IRQ_MASK);
  wire               rd_tie      = (s_axi_araddr == ADDR_TIE_DELAY);
  wire               rd_mapped   = rd_status | rd_ctrl | rd_irq_st | rd_irq_mask | rd_tie;
  wire [DATA_W-1:0]  rd_data     = rd_status   ? status_word :
                                   rd_ctrl     ? {30'h0000_0000, ctrl_ref} :
                                   rd_irq_st   ? {26'h000_0000, irq_status} :
                                   rd_irq_mask ? {26'h000_0000, irq_mask} :
                                   rd_tie      ? {16'h0000, tie_delay} :
                                                 32'h0000_0000;

  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
endmodule
`default_nettype wire

// File: dpll_status_mode_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dpll_status_mode_ctrl_chk
  import dpll_ctrl_pkg::*;
#(
  parameter int unsigned RESET_HOLD = 20
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic op_setting_bit0,
  input wire logic op_setting_bit1,
  input wire logic freq_lock_flag,
  input wire logic holdover_flag,
  input wire logic input_b_fault_flag,
  input wire logic frame_pulse,
  input wire logic frame_pulse_oe,
  input wire logic irq,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  wire logic [1:0] mode_code = {op_setting_bit1, op_setting_bit0};
  int unsigned     since_rel;
  // cycles since release, saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_rel <= 0;
    end else if (since_rel < RESET_HOLD + 8) begin
      since_rel <= since_rel + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  oe_early_a: assert property (frame_pulse_oe |-> since_rel >= RESET_HOLD)
    else $error("oe in reset state");
  oe_late_a: assert property (since_rel > RESET_HOLD + 6 |-> frame_pulse_oe)
    else $error("oe late");
  pulse_oe_a: assert property (frame_pulse |-> frame_pulse_oe)
    else $error("pulse while floated");
  lock_excl_a: assert property (freq_lock_flag |-> !holdover_flag)
    else $error("lock with holdover");
  freerun_flags_a: assert property ((mode_code == MODE_FREERUN) [*5]
    |-> !freq_lock_flag && !holdover_flag)
    else $error("flag raised in freerun");
  hold_nolock_a: assert property ((mode_code == MODE_HOLDOVER) [*5]
    |-> !freq_lock_flag)
    else $error("lock flag raised in holdover code");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken with b pending");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken with r pending");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("b not retired");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("r not retired");
  lock_seen_c: cover property ($rose(freq_lock_flag));
  hold_seen_c: cover property ($rose(holdover_flag));
  fault_seen_c: cover property ($rose(input_b_fault_flag));
  irq_seen_c: cover property ($rose(irq));
endmodule
bind dpll_status_mode_ctrl dpll_status_mode_ctrl_chk #(.RESET_HOLD(RESET_HOLD))
  i_dpll_status_mode_ctrl_chk (.*);
`default_nettype wire

// File: ref_gen.sv
`timescale 1ns/100ps
`default_nettype none
module ref_gen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       wobble,
  input  wire logic [7:0] period,
  output var  logic       ref_out
);
  logic            odd;
  logic      [7:0] cnt;
  wire logic [7:0] lim = period + ((wobble && odd) ? 8'h02 : 8'h00);
  // a paused source keeps its count, so a pause shifts its phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      odd <= 1'b0;
    end else if (run) begin
      cnt <= (cnt >= lim - 8'h01) ? 8'h00 : cnt + 8'h01;
      odd <= (cnt == 8'h00) ? !odd : odd;
    end
  end
  // one-cycle pulse per period, low while stopped
  assign ref_out = run && (cnt == 8'h00);
endmodule
`default_nettype wire

// File: ref_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ref_monitor #(
  parameter logic [dpll_ctrl_pkg::PERIOD_W-1:0] NOM    = dpll_ctrl_pkg::NOM_PERIOD,
  parameter logic [dpll_ctrl_pkg::PERIOD_W-1:0] NARROW = dpll_ctrl_pkg::LIMIT_NARROW,
  parameter logic [dpll_ctrl_pkg::PERIOD_W-1:0] WIDE   = dpll_ctrl_pkg::LIMIT_WIDE,
  parameter logic [dpll_ctrl_pkg::PERIOD_W-1:0] JUMP   = dpll_ctrl_pkg::JUMP_LIMIT
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ref_in,
  input  wire logic wide_range,
  output var  logic fault,
  output var  logic edge_seen
);
  import dpll_ctrl_pkg::*;
  localparam int W = PERIOD_W;

  if (WIDE < NARROW || NOM <= WIDE) begin : g_bad_limits
    $error("range limits must be ordered and below the nominal period");
  end

  logic         ref_prev;
  logic         have_last;
  logic [W-1:0] cnt;
  logic [W-1:0] last_period;

  // period measured between rising edges
  wire         rise   = ref_in & ~ref_prev;
  wire [W-1:0] period = cnt + 1'h1;
  wire [W-1:0] limit  = wide_range ? WIDE : NARROW;
  wire [W-1:0] dev    = (period > NOM) ? period - NOM : NOM - period;
  wire [W-1:0] step   = (period > last_period) ? period - last_period
                                               : last_period - period;
  wire         out_of_range = (dev > limit);
  wire         abrupt       = have_last & (step > JUMP);
  // a missing edge is out of range too, caught before it arrives
  wire         too_slow     = (cnt >= W'(NOM + limit));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev    <= 1'h0;
      have_last   <= 1'h0;
      cnt         <= '0;
      last_period <= '0;
      fault       <= 1'h0;
      edge_seen   <= 1'h0;
    end else begin
      ref_prev  <= ref_in;
      edge_seen <= rise;
      if (rise) begin
        cnt         <= '0;
        last_period <= period;
        have_last   <= 1'h1;
        fault       <= out_of_range | abrupt;  // [RL3] [RL4]
      end else begin
        if (~&cnt) cnt <= cnt + 1'h1;
        if (too_slow) fault <= 1'h1;  // [RL3]
      end
    end
  end
endmodule
`default_nettype wire

// File: reset_hold.sv
`timescale 1ns/100ps
`default_nettype none
module reset_hold #(
  parameter int unsigned HOLD = dpll_ctrl_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic busy
);
  import dpll_ctrl_pkg::*;
  localparam int CW = $clog2(HOLD + 1);

  if (HOLD < 1) begin : g_bad_hold
    $error("reset hold needs at least one cycle");
  end

  logic [CW-1:0] cnt;
  wire           last = (cnt == CW'(HOLD - 1));

  // busy from reset until the hold count has run out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      busy <= 1'h1;
    end else if (busy) begin
      cnt  <= cnt + 1'h1;
      busy <= ~last;
    end
  end
endmodule
`default_nettype wire

// File: tb_dpll_status_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dpll_status_mode_ctrl;
  import dpll_ctrl_pkg::*;
  localparam int          HOLD = 20;
  localparam logic [7:0]  TP [4] = '{8'h1B, 8'h1B, 8'h1D, 8'h17};
  localparam logic [3:0]  TW = 4'h6;
  logic              core_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [2:0]        run = 3'h7;
  logic [2:0]        wob = 3'h0;
  logic [7:0]        per [3] = '{default: 8'h19};
  logic [2:0]        refs, fault;
  logic              range_sel = 1'b0;
  logic              rebuild = 1'b0;
  logic [1:0]        mode = MODE_NORMAL;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic              aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0;
  logic [DATA_W-1:0] wdata = '0, rdata, d0, d1, st;
  logic              aw_r, w_r, b_v, ar_r, r_v, irq, lock, hold, oe;
  logic [1:0]        bresp, rresp, wr_resp, rd_resp;
  int                failures = 0, num_checks = 0, cycles = 0;
  // master timing from one free-running source
  always #20 core_clk = ~core_clk;
  dpll_status_mode_ctrl #(.RESET_HOLD(HOLD)) i_dpll_status_mode_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .input_a(refs[0]), .input_b(refs[1]),
    .input_c(refs[2]), .range_limit_choice(range_sel), .phase_rebuild_select(rebuild),
    .op_setting_bit0(mode[0]), .op_setting_bit1(mode[1]), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(bresp), .s_axi_bvalid(b_v),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(1'b1),
    .freq_lock_flag(lock), .holdover_flag(hold), .input_a_fault_flag(fault[0]),
    .input_b_fault_flag(fault[1]), .input_c_fault_flag(fault[2]), .frame_pulse(),
    .frame_pulse_oe(oe), .irq(irq));
  for (genvar g = 0; g < 3; g++) begin : g_ref
    ref_gen i_ref_gen (.clk(core_clk), .rst_n(rst_n), .run(run[g]), .wobble(wob[g]),
      .period(per[g]), .ref_out(refs[g]));
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // readies held high: response taken when seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
      if (b_v === 1'b1) break;
    end
    wr_resp = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    ar_v <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (ar_v && ar_r) ar_v <= 1'b0;
      if (r_v === 1'b1) break;
    end
    d = rdata;
    rd_resp = rresp;
  endtask
  // irq is registered: two edges to settle
  task automatic wr_irq(input logic [7:0] a, input logic [31:0] d, input logic e);
    wr(a, d);
    repeat (2) @(posedge core_clk);
    check(irq, e, "irq level");
  endtask
  function automatic logic exp_fault(input logic [7:0] p, input logic w);
    int dev;
    dev = int'(p) - int'(NOM_PERIOD);
    if (dev < 0) dev = -dev;
    return dev > int'(w ? LIMIT_WIDE : LIMIT_NARROW);
  endfunction
  function automatic logic [1:0] exp_lh(input logic [1:0] c);
    return {c == MODE_NORMAL || c == MODE_AUTO, c == MODE_HOLDOVER};
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard; sequence needs about 4000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    logic [7:0] p;
    logic       w;
    void'($urandom(11));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    // reset state, reset values, unmapped
    check(oe, 0, "oe in reset state");
    rd(ADDR_STATUS, st);
    check(st[7], 1, "reset state bit");
    rd(ADDR_CONTROL, st);
    check(st, 0, "control reset");
    rd(ADDR_IRQ_MASK, st);
    check(st, 0, "mask reset");
    rd(8'h14, st);
    check({rd_resp, st}, {RESP_SLVERR, 32'h0000_0000}, "unmapped read");
    wr(8'h14, 32'h0000_0001);
    check(wr_resp, RESP_SLVERR, "unmapped write");
    repeat (HOLD + 10) @(posedge core_clk);
    check(oe, 1, "oe after reset state");
    $display("test reset done");
    // lock on the selected reference, then lock-gain interrupt
    repeat (300) @(posedge core_clk);
    check({lock, hold}, 2'b10, "locked on a");
    rd(ADDR_STATUS, st);
    check({st[10], st[9:8], st[0]}, 4'b1001, "status lock");
    wr_irq(ADDR_IRQ_MASK, 32'h0000_0001, 1'b1);
    wr_irq(ADDR_IRQ_MASK, 32'h0000_0000, 1'b0);
    wr_irq(ADDR_IRQ_STATUS, 32'h0000_0001, 1'b0);
    wr_irq(ADDR_IRQ_MASK, 32'h0000_0001, 1'b0);
    rd(ADDR_TIE_DELAY, d0);
    $display("test lock done");
    // holdover, shift a's phase, return with select low then high
    for (int s = 0; s < 2; s++) begin
      mode <= MODE_HOLDOVER;
      rebuild <= s[0];
      repeat (6) @(posedge core_clk);
      check({lock, hold}, 2'b01, "holdover");
      run[0] <= 1'b0;
      repeat (7) @(posedge core_clk);
      run[0] <= 1'b1;
      mode <= MODE_NORMAL;
      repeat (400) @(posedge core_clk);
      rd(ADDR_TIE_DELAY, d1);
      check(lock, 1, "relock");
      check(d1 == d0, s == 0, "corrector delay");
    end
    rd(ADDR_IRQ_STATUS, st);
    check({st[IRQ_FAULT_LSB], st[IRQ_HOLDOVER]}, 2'b11, "events");
    $display("test hitless done");
    // range on b: corners, then random; then abrupt change and steady on c
    for (int i = 0; i < 8; i++) begin
      p = (i < 4) ? TP[i] : 8'h14 + 8'($urandom % 11);
      w = (i < 4) ? TW[i] : 1'($urandom % 2);
      per[1] <= p;
      range_sel <= w;
      repeat (160) @(posedge core_clk);
      check(fault[1], exp_fault(p, w), "range fault b");
    end
    per[1] <= 8'h19;
    range_sel <= 1'b1;
    wob[2] <= 1'b1;
    repeat (150) @(posedge core_clk);
    check(fault[2], 1, "abrupt change c");
    wob[2] <= 1'b0;
    repeat (150) @(posedge core_clk);
    check(fault[2], 0, "steady c");
    $display("test faults done");
    // every mode code in turn
    for (int c = 0; c < 4; c++) begin
      mode <= 2'(c);
      repeat (300) @(posedge core_clk);
      rd(ADDR_STATUS, st);
      check({st[6:5], lock, hold}, {2'(c), exp_lh(2'(c))}, "mode code");
    end
    $display("test modes done");
    conclude();
  end
endmodule
`default_nettype wire
